// *** design/dbc_pkg.sv ***
// package: constants of the dynamic brake chopper control
// ============================================================
// Notes on behaviour
// - braking runs only while enabled, default on
// - sample link voltage every millisecond tick
// - switch on above threshold, else off
// - accounting runs without motor output enabled
// - track resistor and switch energy, derive loading
// - accumulate power excess times time
// - area at limit forces switch off
// - threshold 764V rising linearly to 773V
// - hold setpoint while brake conducts
// - braking active status is read only
// - resistance 0.01..1000.00 ohm, default 100.00, stopped
// - rated power 0.10..510.00 kW, default 0.10, stopped
// - overrating 1.00..40.00, default 25.00, stopped
package dbc_pkg;
	// ============================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS  = 32'h0000_0064;
	localparam int unsigned TICK_PERIOD_NS = 32'h000f_4240;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// ============================================================
	// widths
	localparam int unsigned VW = 32'h0000_000a;
	localparam int unsigned RW = 32'h0000_0011;
	localparam int unsigned PW = 32'h0000_0010;
	localparam int unsigned OW = 32'h0000_000c;
	localparam int unsigned AW = 32'h0000_0028;
	localparam int unsigned QW = 32'h0000_0015;
	// ============================================================
	// register offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_RES   = 8'h04;
	localparam logic [7:0] OFF_RATED = 8'h08;
	localparam logic [7:0] OFF_OVR   = 8'h0c;
	localparam logic [7:0] OFF_STATE = 8'h10;
	localparam logic [7:0] OFF_AREA  = 8'h14;
	localparam logic [7:0] OFF_ERES  = 8'h18;
	localparam logic [7:0] OFF_ESW   = 8'h1c;
	localparam logic [7:0] OFF_ISTAT = 8'h20;
	localparam logic [7:0] OFF_IMASK = 8'h24;
	// ============================================================
	// field positions
	localparam int unsigned CTRL_EN_BIT  = 32'h0000_0000;
	localparam int unsigned ST_SW_BIT    = 32'h0000_0000;
	localparam int unsigned ST_LOCK_BIT  = 32'h0000_0001;
	localparam int unsigned ST_HOLD_BIT  = 32'h0000_0002;
	localparam int unsigned ST_V_LSB     = 32'h0000_0010;
	localparam int unsigned IRQ_ON_BIT   = 32'h0000_0000;
	localparam int unsigned IRQ_LOCK_BIT = 32'h0000_0001;
	localparam int unsigned IRQ_REF_BIT  = 32'h0000_0002;
	localparam int unsigned IRQ_W        = 32'h0000_0003;
	// ============================================================
	// reset values and ranges (ohm x100, kW x100, ratio x100)
	localparam logic          EN_RST    = 1'b1;
	localparam logic [RW-1:0] RES_RST   = 17'h0_2710;
	localparam logic [RW-1:0] RES_MIN   = 17'h0_0001;
	localparam logic [RW-1:0] RES_MAX   = 17'h1_86a0;
	localparam logic [PW-1:0] RATED_RST = 16'h000a;
	localparam logic [PW-1:0] RATED_MIN = 16'h000a;
	localparam logic [PW-1:0] RATED_MAX = 16'hc738;
	localparam logic [OW-1:0] OVR_RST   = 12'h9c4;
	localparam logic [OW-1:0] OVR_MIN   = 12'h064;
	localparam logic [OW-1:0] OVR_MAX   = 12'hfa0;
	// ============================================================
	// arithmetic scales
	localparam logic [VW-1:0] VTH_BASE    = 10'h2fc;
	localparam logic [3:0]    VTH_SPAN    = 4'h9;
	localparam logic [10:0]   I_SCALE     = 11'h640;
	localparam logic [3:0]    RATED_W_SC  = 4'ha;
	localparam logic [6:0]    LIMIT_SC    = 7'h64;
	localparam logic [OW-1:0] OVR_UNITY   = 12'h064;
	localparam logic [3:0]    SW_DROP_V   = 4'h2;
	localparam int unsigned   I_FRAC      = 32'h0000_0004;
endpackage

// *** design/dbc_div_if.sv ***
// interface: request and answer of the current divider
`timescale 1ns/1ps
interface dbc_div_if;
	logic                     start;
	logic [dbc_pkg::QW-1:0]   num;
	logic [dbc_pkg::RW-1:0]   den;
	logic                     done;
	logic [dbc_pkg::QW-1:0]   quo;
	modport master (output start, output num, output den, input done, input quo);
	modport slave  (input start, input num, input den, output done, output quo);
endinterface

// *** design/dbc_divider.sv ***
// module: serial restoring divider for the braking current
`timescale 1ns/1ps
module dbc_divider (
	input wire logic pclk,    // system clock
	input wire logic presetn, // async reset, active low
	dbc_div_if.slave div      // divider request and answer
);
	localparam int unsigned NW = dbc_pkg::QW;
	localparam int unsigned DW = dbc_pkg::RW;

	logic [DW:0]   rem_q;
	logic [NW-1:0] quo_q;
	logic [4:0]    cnt_q;
	logic          done_q;
	logic [DW:0]   trial;

	assign trial = {rem_q[DW-1:0], quo_q[NW-1]};
	assign div.quo = quo_q;
	assign div.done = done_q;

	// ============================================================
	// one quotient bit per clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_q <= '0;
			quo_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (div.start) begin
				rem_q <= '0;
				quo_q <= div.num;
				cnt_q <= 5'(NW);
			end else if (cnt_q != 5'h00) begin
				cnt_q <= cnt_q - 5'h01;
				done_q <= (cnt_q == 5'h01);
				if (trial >= {1'b0, div.den}) begin
					rem_q <= trial - {1'b0, div.den};
					quo_q <= {quo_q[NW-2:0], 1'b1};
				end else begin
					rem_q <= trial;
					quo_q <= {quo_q[NW-2:0], 1'b0};
				end
			end
		end
	end
endmodule // dbc_divider

// *** design/dbc_brake_ctrl.sv ***
// module: dynamic brake chopper control with apb registers
`timescale 1ns/1ps
module dbc_brake_ctrl #(
	parameter int unsigned TICK_CYCLES = dbc_pkg::TICK_CYCLES,
	parameter logic [3:0]  SW_DROP_V   = dbc_pkg::SW_DROP_V
) (
	input  wire logic        pclk,          // 10 MHz clock
	input  wire logic        presetn,       // async reset, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb enable
	input  wire logic        pwrite,        // apb direction
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	input  wire logic [9:0]  vdc_volts,     // dc link voltage, volts
	input  wire logic        drive_stopped, // drive sequencer stopped
	output logic             brake_switch,  // brake switch gate
	output logic             setpoint_hold, // slew limiter freeze
	output logic             irq            // interrupt, level
);
	localparam int unsigned VW = dbc_pkg::VW;
	localparam int unsigned AW = dbc_pkg::AW;

	dbc_div_if div ();

	dbc_divider u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.div     (div.slave)
	);

	function automatic logic in_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		in_rng = (v >= lo) && (v <= hi);
	endfunction

	// ============================================================
	// voltage synchroniser
	// the adc word is held for many clocks, so a vector sync is safe
	logic [VW-1:0] vdc_m_q;
	logic [VW-1:0] vdc_s_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vdc_m_q <= '0;
			vdc_s_q <= '0;
		end else begin
			vdc_m_q <= vdc_volts;
			vdc_s_q <= vdc_m_q;
		end
	end

	// ============================================================
	// millisecond tick
	logic [31:0] tick_cnt_q;
	logic        tick;
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
		end
	end

	// ============================================================
	// apb decode
	// one wait state so read data comes from a flop
	logic rdy_q;
	logic acc;
	logic commit;
	logic wr;
	logic mapped;
	logic ro_addr;
	logic wr_res;
	logic wr_rat;
	logic wr_ovr;
	logic res_ok;
	logic rat_ok;
	logic ovr_ok;
	logic wr_bad;
	assign acc = psel & penable;
	assign commit = acc & rdy_q;
	assign wr = commit & pwrite;
	assign pready = rdy_q;
	assign ro_addr = (paddr == dbc_pkg::OFF_STATE) || (paddr == dbc_pkg::OFF_AREA) ||
		(paddr == dbc_pkg::OFF_ERES) || (paddr == dbc_pkg::OFF_ESW);
	assign mapped = ro_addr || (paddr == dbc_pkg::OFF_CTRL) || (paddr == dbc_pkg::OFF_RES) ||
		(paddr == dbc_pkg::OFF_RATED) || (paddr == dbc_pkg::OFF_OVR) ||
		(paddr == dbc_pkg::OFF_ISTAT) || (paddr == dbc_pkg::OFF_IMASK);
	assign wr_res = wr && (paddr == dbc_pkg::OFF_RES);
	assign wr_rat = wr && (paddr == dbc_pkg::OFF_RATED);
	assign wr_ovr = wr && (paddr == dbc_pkg::OFF_OVR);
	assign res_ok = drive_stopped && in_rng(pwdata, 32'(dbc_pkg::RES_MIN), 32'(dbc_pkg::RES_MAX));
	assign rat_ok = drive_stopped && in_rng(pwdata, 32'(dbc_pkg::RATED_MIN), 32'(dbc_pkg::RATED_MAX));
	assign ovr_ok = drive_stopped && in_rng(pwdata, 32'(dbc_pkg::OVR_MIN), 32'(dbc_pkg::OVR_MAX));
	assign wr_bad = (wr_res & ~res_ok) | (wr_rat & ~rat_ok) | (wr_ovr & ~ovr_ok) |
		(wr & ro_addr);
	assign pslverr = commit & (~mapped | wr_bad);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= acc & ~rdy_q;
		end
	end

	// ============================================================
	// settings
	logic                     enable_q;
	logic [dbc_pkg::RW-1:0]   res_q;
	logic [dbc_pkg::PW-1:0]   rat_q;
	logic [dbc_pkg::OW-1:0]   ovr_q;
	logic [dbc_pkg::IRQ_W-1:0] mask_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_q <= dbc_pkg::EN_RST;
			res_q <= dbc_pkg::RES_RST;
			rat_q <= dbc_pkg::RATED_RST;
			ovr_q <= dbc_pkg::OVR_RST;
			mask_q <= '0;
		end else begin
			if (wr && (paddr == dbc_pkg::OFF_CTRL)) begin
				enable_q <= pwdata[dbc_pkg::CTRL_EN_BIT];
			end
			if (wr_res && res_ok) begin
				res_q <= pwdata[dbc_pkg::RW-1:0];
			end
			if (wr_rat && rat_ok) begin
				rat_q <= pwdata[dbc_pkg::PW-1:0];
			end
			if (wr_ovr && ovr_ok) begin
				ovr_q <= pwdata[dbc_pkg::OW-1:0];
			end
			if (wr && (paddr == dbc_pkg::OFF_IMASK)) begin
				mask_q <= pwdata[dbc_pkg::IRQ_W-1:0];
			end
		end
	end

	// ============================================================
	// threshold and overload limit
	// comparing (v-764)*limit against 9*area keeps the linear rise
	// exact without a second divider
	logic [AW-1:0] area_q;
	logic [AW-1:0] lim;
	logic [47:0]   lhs;
	logic [47:0]   rhs;
	logic          above;
	logic          lock;
	assign lim = AW'(ovr_q - dbc_pkg::OVR_UNITY) * AW'(rat_q) * AW'(dbc_pkg::LIMIT_SC);
	assign lock = (area_q >= lim);
	assign lhs = 48'(vdc_s_q - dbc_pkg::VTH_BASE) * 48'(lim);
	assign rhs = 48'(area_q) * 48'(dbc_pkg::VTH_SPAN);
	assign above = (vdc_s_q > dbc_pkg::VTH_BASE) && (lhs > rhs);

	// ============================================================
	// brake switch
	logic          switch_q;
	logic [VW-1:0] v_q;
	logic          lock_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_q <= 1'b0;
		end else if (!enable_q || lock) begin
			switch_q <= 1'b0;
		end else if (tick) begin
			switch_q <= above;
		end
	end

	// accounting keeps running whatever the motor output does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v_q <= '0;
			lock_q <= 1'b0;
		end else begin
			lock_q <= lock;
			if (tick) begin
				v_q <= vdc_s_q;
			end
		end
	end

	assign brake_switch = switch_q;
	assign setpoint_hold = switch_q;

	// ============================================================
	// current, power and energy
	// current in 1/16 A: v*1600/(ohm x100)
	assign div.start = tick;
	assign div.num = dbc_pkg::QW'(vdc_s_q) * dbc_pkg::QW'(dbc_pkg::I_SCALE);
	assign div.den = res_q;

	logic [31:0] p_w;
	logic [31:0] pbrk;
	logic [31:0] psw;
	logic [31:0] rated_w;
	logic        over;
	logic [31:0] eres_q;
	logic [31:0] esw_q;
	assign p_w = (32'(v_q) * 32'(div.quo)) >> dbc_pkg::I_FRAC;
	assign pbrk = switch_q ? p_w : 32'h0000_0000;
	assign psw = switch_q ? ((32'(div.quo) * 32'(SW_DROP_V)) >> dbc_pkg::I_FRAC) : 32'h0000_0000;
	assign rated_w = 32'(rat_q) * 32'(dbc_pkg::RATED_W_SC);
	assign over = (pbrk > rated_w);

	// watts over one millisecond are millijoules
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eres_q <= '0;
			esw_q <= '0;
		end else if (div.done) begin
			eres_q <= eres_q + pbrk;
			esw_q <= esw_q + psw;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			area_q <= '0;
		end else if (div.done) begin
			if (over) begin
				area_q <= area_q + AW'(pbrk - rated_w);
			end else if (area_q > AW'(rated_w - pbrk)) begin
				area_q <= area_q - AW'(rated_w - pbrk);
			end else begin
				area_q <= '0;
			end
		end
	end

	// ============================================================
	// interrupts
	// only bits already returned by the read are cleared, so an
	// event during the wait state survives
	logic [dbc_pkg::IRQ_W-1:0] istat_q;
	logic [dbc_pkg::IRQ_W-1:0] iset;
	logic [dbc_pkg::IRQ_W-1:0] iclr;
	always_comb begin
		iset = '0;
		iset[dbc_pkg::IRQ_ON_BIT] = tick & enable_q & ~lock & above & ~switch_q;
		iset[dbc_pkg::IRQ_LOCK_BIT] = lock & ~lock_q;
		iset[dbc_pkg::IRQ_REF_BIT] = wr_bad;
		iclr = (commit && !pwrite && (paddr == dbc_pkg::OFF_ISTAT)) ?
			prdata[dbc_pkg::IRQ_W-1:0] : '0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_q <= '0;
		end else begin
			istat_q <= (istat_q & ~iclr) | iset;
		end
	end
	assign irq = |(istat_q & mask_q);

	// ============================================================
	// read data
	logic [31:0] rd_d;
	logic [31:0] prdata_q;
	always_comb begin
		rd_d = '0;
		case (paddr)
			dbc_pkg::OFF_CTRL: rd_d[dbc_pkg::CTRL_EN_BIT] = enable_q;
			dbc_pkg::OFF_RES: rd_d = 32'(res_q);
			dbc_pkg::OFF_RATED: rd_d = 32'(rat_q);
			dbc_pkg::OFF_OVR: rd_d = 32'(ovr_q);
			dbc_pkg::OFF_STATE: begin
				rd_d[dbc_pkg::ST_SW_BIT] = switch_q;
				rd_d[dbc_pkg::ST_LOCK_BIT] = lock;
				rd_d[dbc_pkg::ST_HOLD_BIT] = switch_q;
				rd_d[dbc_pkg::ST_V_LSB +: VW] = v_q;
			end
			dbc_pkg::OFF_AREA: rd_d = area_q[31:0];
			dbc_pkg::OFF_ERES: rd_d = eres_q;
			dbc_pkg::OFF_ESW: rd_d = esw_q;
			dbc_pkg::OFF_ISTAT: rd_d = 32'(istat_q);
			dbc_pkg::OFF_IMASK: rd_d = 32'(mask_q);
			default: rd_d = '0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (acc && !rdy_q) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
		end
	end
	assign prdata = prdata_q;

	// ============================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_enable_off: assert property (!enable_q |=> !switch_q)
		else $error("brake switch on while disabled");
	chk_switch_tick: assert property ($rose(switch_q) |-> $past(tick) && $past(above))
		else $error("brake switch closed off the tick");
	chk_switch_cmp: assert property (tick && enable_q && !lock |=> switch_q == $past(above))
		else $error("brake switch does not follow comparison");
	chk_lock_off: assert property (lock |=> !switch_q [*2])
		else $error("brake switch on at overload limit");
	chk_area_grow: assert property (div.done && over |=> area_q == $past(area_q) + AW'($past(pbrk) - $past(rated_w)))
		else $error("overload area not accumulated");
	chk_area_decay: assert property (div.done && !over |=> area_q <= $past(area_q))
		else $error("overload area grew below rating");
	chk_energy_res: assert property (div.done |=> eres_q == $past(eres_q) + $past(pbrk))
		else $error("resistor energy not tracked");
	chk_hold_brake: assert property ($rose(switch_q) |-> setpoint_hold && brake_switch)
		else $error("setpoint hold missing while braking");
	chk_ro_status: assert property (wr && ro_addr |-> pslverr ##1 switch_q == $past(switch_q) || $past(tick))
		else $error("write to status accepted");
	chk_res_stopped: assert property (wr_res && !drive_stopped |=> res_q == $past(res_q))
		else $error("resistance written while running");
	chk_rated_rng: assert property (wr_rat && pwdata < 32'(dbc_pkg::RATED_MIN) |=> rat_q == $past(rat_q))
		else $error("rated power out of range accepted");
	chk_ovr_rng: assert property (wr_ovr && pwdata > 32'(dbc_pkg::OVR_MAX) |=> ovr_q == $past(ovr_q))
		else $error("overrating out of range accepted");
	chk_div_time: assert property (tick |-> ##[21:22] div.done)
		else $error("accounting step missing after tick");
	chk_threshold: assert property (tick && enable_q && !lock && vdc_s_q <= dbc_pkg::VTH_BASE |=> !switch_q)
		else $error("brake below base threshold");

	cov_brake_on: cover property (tick ##1 $rose(switch_q));
	cov_lockout: cover property ($rose(lock));
	cov_irq: cover property ($rose(irq));
	cov_refused: cover property (wr_bad);
endmodule // dbc_brake_ctrl

// *** tb/dbc_link_model.sv ***
// partner model: dc link voltage sensing beside the brake switch
`timescale 1ns/1ps
module dbc_link_model (
	input  wire logic        pclk,         // system clock
	input  wire logic        presetn,      // async reset, active low
	input  wire logic [9:0]  vdc_target,   // link level chosen by the bench
	input  wire logic        brake_switch, // gate driven by the device
	output logic      [9:0]  vdc_volts,    // sensed link voltage
	output int unsigned      closures      // count of switch closures
);
	// ============================================================
	// sense path
	// word moves only on an edge, so the sync never sees a torn value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vdc_volts <= 10'h000;
		end else begin
			vdc_volts <= vdc_target;
		end
	end
	// ============================================================
	// switch watch
	logic sw_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_q     <= 1'b0;
			closures <= 0;
		end else begin
			sw_q <= brake_switch;
			if (brake_switch && !sw_q) begin
				closures <= closures + 1;
			end
		end
	end
endmodule // dbc_link_model

// *** tb/testbench.sv ***
// testbench: apb stimulus and behavioural model of the brake chopper control
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
	$display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	localparam int unsigned TK = 50;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        drive_stopped, brake_switch, setpoint_hold, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0]  vdc_target, vdc_volts;
	logic        err;
	int unsigned closures;
	int          num_errors, tests_run, rv;
	int unsigned ra[$] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0008, 32'h0000_000c, 32'h0000_0024};
	int unsigned rr[$] = '{32'h0000_0001, 32'h0000_2710, 32'h0000_000a, 32'h0000_09c4, 32'h0000_0000};
	int unsigned ta[$] = '{32'h0000_0004, 32'h0000_0004, 32'h0000_0008, 32'h0000_0008, 32'h0000_000c, 32'h0000_000c};
	int unsigned td[$] = '{32'h0000_0000, 32'h0001_86a1, 32'h0000_0009, 32'h0000_c739, 32'h0000_0063, 32'h0000_0fa1};
	int unsigned vq[$];

	dbc_brake_ctrl #(.TICK_CYCLES(TK), .SW_DROP_V(4'h2)) dbc_brake_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vdc_volts(vdc_volts), .drive_stopped(drive_stopped), .brake_switch(brake_switch),
		.setpoint_hold(setpoint_hold), .irq(irq));
	dbc_link_model dbc_link_model_i (.pclk(pclk), .presetn(presetn), .vdc_target(vdc_target),
		.brake_switch(brake_switch), .vdc_volts(vdc_volts), .closures(closures));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ============================================================
	// model and bus tasks
	function automatic logic model_on(int v, int en, longint area, longint lim);
		return en != 0 && area < lim && v > 764 && longint'(v - 764) * lim > 9 * area;
	endfunction

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		`CHK("pslverr", e, err)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0000_0000);
		`CHK("prdata", ex, rd)
		`CHK("pslverr", 1'b0, err)
	endtask

	task automatic settle(input logic [9:0] v, input int nt);
		vdc_target <= v;
		repeat (nt * TK) @(posedge pclk);
	endtask

	// ============================================================
	// main sequence
	initial begin
		void'($urandom(32'h9b13));
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		drive_stopped = 1'b1;
		vdc_target = 10'h000;
		num_errors = 0;
		tests_run = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) rd_chk(ra[i][7:0], rr[i]);
		$display("test reset values done");

		drive_stopped <= 1'b0;
		wr(dbc_pkg::OFF_RES, 32'h0000_1388, 1'b1);
		wr(dbc_pkg::OFF_STATE, 32'h0000_0001, 1'b1);
		rd_chk(dbc_pkg::OFF_RES, 32'h0000_2710);
		drive_stopped <= 1'b1;
		foreach (ta[i]) wr(ta[i][7:0], td[i], 1'b1);
		rv = 1 + $urandom % 100000;
		wr(dbc_pkg::OFF_RES, rv, 1'b0);
		rd_chk(dbc_pkg::OFF_RES, rv);
		wr(dbc_pkg::OFF_RATED, 32'h0000_c738, 1'b0);
		rd_chk(dbc_pkg::OFF_RATED, 32'h0000_c738);
		wr(dbc_pkg::OFF_OVR, 32'h0000_0064, 1'b0);
		rd_chk(dbc_pkg::OFF_OVR, 32'h0000_0064);
		foreach (ra[i]) wr(ra[i][7:0], rr[i], 1'b0);
		apb(1'b0, 8'h28, 32'h0000_0000);
		`CHK("unmapped err", 1'b1, err)
		// ovr 1.00 leaves a zero limit, so the lock bit rose beside the refusals
		rd_chk(dbc_pkg::OFF_ISTAT, 32'h0000_0006);
		rd_chk(dbc_pkg::OFF_ISTAT, 32'h0000_0000);
		`CHK("irq masked", 1'b0, irq)
		$display("test settings access done");

		wr(dbc_pkg::OFF_IMASK, 32'h0000_0001, 1'b0);
		drive_stopped <= 1'b0;
		vq = '{764, 765, $urandom % 764, 800};
		foreach (vq[i]) begin
			settle(vq[i], 3);
			`CHK("switch", model_on(vq[i], 1, 0, 2400000), brake_switch)
			`CHK("hold", model_on(vq[i], 1, 0, 2400000), setpoint_hold)
		end
		`CHK("closures", 2, closures)
		`CHK("irq on", 1'b1, irq)
		rd_chk(dbc_pkg::OFF_ISTAT, 32'h0000_0001);
		// the clear lands on the completing edge, so look one edge later
		@(posedge pclk);
		`CHK("irq clear", 1'b0, irq)
		rd_chk(dbc_pkg::OFF_STATE, 32'h0320_0005);
		apb(1'b0, dbc_pkg::OFF_ERES, 32'h0000_0000);
		`CHK("eres", 1'b1, rd != 0)
		apb(1'b0, dbc_pkg::OFF_ESW, 32'h0000_0000);
		`CHK("esw", 1'b1, rd != 0)
		$display("test threshold done");

		wr(dbc_pkg::OFF_CTRL, 32'h0000_0000, 1'b0);
		repeat (3) @(posedge pclk);
		`CHK("switch off", 1'b0, brake_switch)
		settle(800, 2);
		rd_chk(dbc_pkg::OFF_STATE, 32'h0320_0000);
		wr(dbc_pkg::OFF_CTRL, 32'h0000_0001, 1'b0);
		settle(800, 2);
		`CHK("switch back", 1'b1, brake_switch)
		$display("test enable done");

		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		drive_stopped <= 1'b1;
		// ovr 1.01 keeps the limit at 1000 so one hot tick locks
		wr(dbc_pkg::OFF_OVR, 32'h0000_0065, 1'b0);
		wr(dbc_pkg::OFF_IMASK, 32'h0000_0002, 1'b0);
		settle(800, 3);
		`CHK("locked", 1'b0, brake_switch)
		`CHK("irq lock", 1'b1, irq)
		rd_chk(dbc_pkg::OFF_STATE, 32'h0320_0002);
		apb(1'b0, dbc_pkg::OFF_AREA, 32'h0000_0000);
		`CHK("area", 1'b1, rd >= 1000)
		settle(700, 80);
		rd_chk(dbc_pkg::OFF_AREA, 32'h0000_0000);
		rd_chk(dbc_pkg::OFF_STATE, 32'h02bc_0000);
		$display("test overload done");
		report_and_stop();
	end
endmodule // testbench
